// ### include/dpg_pkg.sv
// Constants and register map of the dual-port GPIO block
package dpg_pkg;

   // ****************************************
   // Widths
   // ****************************************
   localparam int DPG_ADDR_W = 12;
   localparam int DPG_DATA_W = 32;
   localparam int DPG_FP_W = 5;
   localparam int DPG_SP_W = 8;
   localparam int DPG_REG_W = 8;
   localparam int DPG_MON_W = 4;

   // ****************************************
   // Register indices (byte address = 4 * index)
   // ****************************************
   localparam logic [7:0] DPG_IDX_FIRST_PORT_PINS = 8'h05;
   localparam logic [7:0] DPG_IDX_FIRST_PORT_DIRECTION = 8'h85;
   localparam logic [7:0] DPG_IDX_SECOND_PORT_PINS = 8'h06;
   localparam logic [7:0] DPG_IDX_SECOND_PORT_DIRECTION = 8'h86;
   localparam logic [7:0] DPG_IDX_OPTION = 8'h81;
   localparam logic [7:0] DPG_IDX_INTERRUPT_CONTROL = 8'h0b;
   localparam logic [7:0] DPG_IDX_BIT_OP = 8'h90;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int DPG_OD_BIT = 4;
   localparam int DPG_OPT_PULLUP_N_BIT = 7;
   localparam int DPG_ICR_GIE_BIT = 7;
   localparam int DPG_ICR_CHG_EN_BIT = 3;
   localparam int DPG_ICR_CHG_FLAG_BIT = 0;
   localparam int DPG_MON_LO = 4;
   localparam int DPG_MON_HI = 7;
   localparam int DPG_BOP_PORT_BIT = 7;
   localparam int DPG_BOP_VAL_BIT = 6;
   localparam int DPG_BOP_IDX_LO = 0;
   localparam int DPG_BOP_IDX_HI = 2;

   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [DPG_FP_W-1:0] DPG_FP_DIR_RST = 5'h1f;
   localparam logic [DPG_SP_W-1:0] DPG_SP_DIR_RST = 8'hff;
   localparam logic [DPG_REG_W-1:0] DPG_OPTION_RST = 8'hff;
   localparam logic [DPG_FP_W-1:0] DPG_FP_LATCH_RST = 5'h00;
   localparam logic [DPG_SP_W-1:0] DPG_SP_LATCH_RST = 8'h00;
   localparam logic [DPG_MON_W-1:0] DPG_REF_RST = 4'h0;
   localparam logic [DPG_DATA_W-1:0] DPG_RD_ZERO = 32'h0000_0000;

endpackage

// ### rtl/dpg_gpio.sv
// Dual-port GPIO with weak pull-ups and change detection, APB slave
`timescale 1ns/1ps
// Operation
// (RL1) First port has a five-bit output latch and one direction bit per pin.
// (RL2) First-port bit 4 is open drain; other first-port pins are push-pull.
// (RL3) First-port bit 4 also feeds the timer's external clock input.
// (RL4) Direction bit 1 floats the driver; 0 drives the latch bit out.
// (RL5) Port reads return pin levels; port writes update only the latch.
// (RL6) Port writes are read-modify-write: pins sampled, modified, stored in latch; here only the bit operation does this, full writes store pwdata.
// (RL7) Any reset sets all five first-port direction bits to 1.
// (RL8) First-port bits 7 to 5 of data and direction read as zero.
// (RL9) Second port is eight bits, bidirectional, same direction polarity.
// (RL10) One shared active-low bit 7 of option enables all second-port pull-ups.
// (RL11) A pull-up is off whenever its pin is set as an output.
// (RL12) Second-port pull-ups are disabled after power-on reset.
// (RL13) Change detection covers only input pins among second-port pins 7 to 4.
// (RL14) Monitored inputs versus last-read value, mismatches OR-ed into change flag.
// (RL15) Mismatch keeps setting the flag; any port access relatches the reference.
// (RL16) Software clears by accessing the second port, then clearing the flag.
// (RL17) The change interrupt can wake the device from sleep.
// (RL18) A pin change coinciding with the port sample may be missed.
// (RL19) Software should not poll the second port while using change interrupts.
// (RL20) Change flag sets regardless of its enable or the global enable.
// (RL21) Interrupt request when flag and enable both set; also wakes from sleep.
module dpg_gpio (
   input wire logic mclk, // System clock, 50 MHz
   input wire logic srst, // Synchronous reset, active high
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB direction, 1 = write
   input wire logic [dpg_pkg::DPG_ADDR_W-1:0] paddr, // APB byte address
   input wire logic [dpg_pkg::DPG_DATA_W-1:0] pwdata, // APB write data
   output logic [dpg_pkg::DPG_DATA_W-1:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error on unmapped address
   input wire logic [dpg_pkg::DPG_FP_W-1:0] fp_pin_in, // First-port pin levels
   output logic [dpg_pkg::DPG_FP_W-1:0] fp_pin_out, // First-port drive value
   output logic [dpg_pkg::DPG_FP_W-1:0] fp_pin_oe, // First-port drive enable
   input wire logic [dpg_pkg::DPG_SP_W-1:0] sp_pin_in, // Second-port pin levels
   output logic [dpg_pkg::DPG_SP_W-1:0] sp_pin_out, // Second-port drive value
   output logic [dpg_pkg::DPG_SP_W-1:0] sp_pin_oe, // Second-port drive enable
   output logic [dpg_pkg::DPG_SP_W-1:0] sp_pullup_on, // Weak pull-up enables
   output logic timer_ext_clk, // Synced open_drain_timer_clock_pin level
   input wire logic sleep_mode, // CPU is asleep
   output logic change_irq, // Change interrupt request
   output logic wake_req // Wake request while asleep
);
   import dpg_pkg::*;

   // ****************************************
   // Decode helpers
   // ****************************************
   function automatic logic reg_hit(
      input logic [DPG_ADDR_W-1:0] addr,
      input logic [7:0] idx
   );
      logic [DPG_ADDR_W-1:0] byte_addr;
      byte_addr = {{(DPG_ADDR_W-10){1'b0}}, idx, 2'b00};
      reg_hit = (addr == byte_addr);
   endfunction

   function automatic logic [DPG_DATA_W-1:0] zext8(input logic [DPG_REG_W-1:0] v);
      zext8 = {{(DPG_DATA_W-DPG_REG_W){1'b0}}, v};
   endfunction

   // ****************************************
   // Declarations
   // ****************************************
   logic [DPG_FP_W-1:0] fp_pins;
   logic [DPG_SP_W-1:0] sp_pins;
   logic [DPG_FP_W-1:0] fp_latch_q;
   logic [DPG_FP_W-1:0] fp_dir_q;
   logic [DPG_SP_W-1:0] sp_latch_q;
   logic [DPG_SP_W-1:0] sp_dir_q;
   logic [DPG_REG_W-1:0] option_q;
   logic gie_q;
   logic chg_en_q;
   logic chg_flag_q;
   logic chg_flag_d;
   logic [DPG_MON_W-1:0] ref_q;
   logic [DPG_DATA_W-1:0] prdata_q;
   logic [DPG_DATA_W-1:0] rd_d;
   logic setup_ph;
   logic access_ph;
   logic wr_acc;
   logic hit_fp_pins;
   logic hit_fp_dir;
   logic hit_sp_pins;
   logic hit_sp_dir;
   logic hit_option;
   logic hit_icr;
   logic hit_bit_op;
   logic mapped;
   logic bop_to_sp;
   logic bop_val;
   logic [2:0] bop_idx;
   logic bop_fp_ok;
   logic [DPG_FP_W-1:0] fp_bop_value;
   logic [DPG_SP_W-1:0] sp_bop_value;
   logic sp_access;
   logic [DPG_MON_W-1:0] mon_pins;
   logic [DPG_MON_W-1:0] mon_inputs;
   logic chg_mismatch;

   // ****************************************
   // Pin synchronisers
   // ****************************************
   dpg_pin_sync #(
      .W(DPG_FP_W)
   ) u_fp_sync (
      .mclk(mclk),
      .srst(srst),
      .pin_async(fp_pin_in),
      .pin_sync(fp_pins)
   );

   dpg_pin_sync #(
      .W(DPG_SP_W)
   ) u_sp_sync (
      .mclk(mclk),
      .srst(srst),
      .pin_async(sp_pin_in),
      .pin_sync(sp_pins)
   );

   // ****************************************
   // APB decode
   // ****************************************
   assign setup_ph = psel & ~penable;
   assign access_ph = psel & penable;
   assign wr_acc = access_ph & pwrite;

   always_comb begin
      hit_fp_pins = 1'b0;
      hit_fp_dir = 1'b0;
      hit_sp_pins = 1'b0;
      hit_sp_dir = 1'b0;
      hit_option = 1'b0;
      hit_icr = 1'b0;
      hit_bit_op = 1'b0;
      if (reg_hit(paddr, DPG_IDX_FIRST_PORT_PINS)) begin
         hit_fp_pins = 1'b1;
      end else if (reg_hit(paddr, DPG_IDX_FIRST_PORT_DIRECTION)) begin
         hit_fp_dir = 1'b1;
      end else if (reg_hit(paddr, DPG_IDX_SECOND_PORT_PINS)) begin
         hit_sp_pins = 1'b1;
      end else if (reg_hit(paddr, DPG_IDX_SECOND_PORT_DIRECTION)) begin
         hit_sp_dir = 1'b1;
      end else if (reg_hit(paddr, DPG_IDX_OPTION)) begin
         hit_option = 1'b1;
      end else if (reg_hit(paddr, DPG_IDX_INTERRUPT_CONTROL)) begin
         hit_icr = 1'b1;
      end else if (reg_hit(paddr, DPG_IDX_BIT_OP)) begin
         hit_bit_op = 1'b1;
      end
   end

   assign mapped = hit_fp_pins | hit_fp_dir | hit_sp_pins | hit_sp_dir
      | hit_option | hit_icr | hit_bit_op;

   // Zero wait states; read data is captured during setup
   assign pready = 1'b1;
   assign pslverr = access_ph & ~mapped;

   // ****************************************
   // Read path
   // ****************************************
   always_comb begin
      rd_d = DPG_RD_ZERO;
      if (hit_fp_pins) begin
         rd_d = zext8({3'b000, fp_pins}); // RL5 RL8
      end else if (hit_fp_dir) begin
         rd_d = zext8({3'b000, fp_dir_q}); // RL8
      end else if (hit_sp_pins) begin
         rd_d = zext8(sp_pins); // RL5
      end else if (hit_sp_dir) begin
         rd_d = zext8(sp_dir_q);
      end else if (hit_option) begin
         rd_d = zext8(option_q);
      end else if (hit_icr) begin
         rd_d[DPG_ICR_GIE_BIT] = gie_q;
         rd_d[DPG_ICR_CHG_EN_BIT] = chg_en_q;
         rd_d[DPG_ICR_CHG_FLAG_BIT] = chg_flag_q;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         prdata_q <= DPG_RD_ZERO;
      end else if (setup_ph && !pwrite) begin
         prdata_q <= rd_d;
      end
   end

   assign prdata = prdata_q;

   // ****************************************
   // Hardware bit operation
   // ****************************************
   // Single-bit set or clear done in hardware: the other bits come
   // from the pins, not the latch, so input pins overwrite their latch
   assign bop_to_sp = pwdata[DPG_BOP_PORT_BIT];
   assign bop_val = pwdata[DPG_BOP_VAL_BIT];
   assign bop_idx = pwdata[DPG_BOP_IDX_HI:DPG_BOP_IDX_LO];
   assign bop_fp_ok = (bop_idx < 3'(DPG_FP_W));

   always_comb begin
      fp_bop_value = fp_pins; // RL6
      sp_bop_value = sp_pins; // RL6
      if (bop_fp_ok) begin
         fp_bop_value[bop_idx] = bop_val;
      end
      sp_bop_value[bop_idx] = bop_val;
   end

   // ****************************************
   // First port
   // ****************************************
   always_ff @(posedge mclk) begin
      if (srst) begin
         fp_latch_q <= DPG_FP_LATCH_RST;
      end else if (wr_acc && hit_fp_pins) begin
         fp_latch_q <= pwdata[DPG_FP_W-1:0]; // RL1 RL5 RL6
      end else if (wr_acc && hit_bit_op && !bop_to_sp) begin
         fp_latch_q <= fp_bop_value; // RL6
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         fp_dir_q <= DPG_FP_DIR_RST; // RL7
      end else if (wr_acc && hit_fp_dir) begin
         fp_dir_q <= pwdata[DPG_FP_W-1:0]; // RL1
      end
   end

   // Push-pull pins drive the latch whenever the direction bit is 0
   // The open-drain pin only ever pulls low
   generate
      for (genvar i = 0; i < DPG_FP_W; i++) begin : g_fp_drv
         if (i == DPG_OD_BIT) begin : g_od
            assign fp_pin_out[i] = 1'b0; // RL2
            assign fp_pin_oe[i] = ~fp_dir_q[i] & ~fp_latch_q[i]; // RL2 RL4
         end else begin : g_pp
            assign fp_pin_out[i] = fp_latch_q[i]; // RL2
            assign fp_pin_oe[i] = ~fp_dir_q[i]; // RL4
         end
      end
   endgenerate

   // Timer sees the pin itself, so an output-low latch also counts
   assign timer_ext_clk = fp_pins[DPG_OD_BIT]; // RL3

   // ****************************************
   // Second port
   // ****************************************
   always_ff @(posedge mclk) begin
      if (srst) begin
         sp_latch_q <= DPG_SP_LATCH_RST;
      end else if (wr_acc && hit_sp_pins) begin
         sp_latch_q <= pwdata[DPG_SP_W-1:0]; // RL5 RL6
      end else if (wr_acc && hit_bit_op && bop_to_sp) begin
         sp_latch_q <= sp_bop_value; // RL6
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         sp_dir_q <= DPG_SP_DIR_RST;
      end else if (wr_acc && hit_sp_dir) begin
         sp_dir_q <= pwdata[DPG_SP_W-1:0]; // RL9
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         option_q <= DPG_OPTION_RST; // RL12
      end else if (wr_acc && hit_option) begin
         option_q <= pwdata[DPG_REG_W-1:0];
      end
   end

   assign sp_pin_out = sp_latch_q; // RL9
   assign sp_pin_oe = ~sp_dir_q; // RL4 RL9

   generate
      for (genvar i = 0; i < DPG_SP_W; i++) begin : g_sp_pull
         // Pull-up fights nothing once the pin drives itself
         assign sp_pullup_on[i] = ~option_q[DPG_OPT_PULLUP_N_BIT] // RL10
            & sp_dir_q[i]; // RL11
      end
   endgenerate

   // ****************************************
   // Change detection
   // ****************************************
   // Any completed access to the second port data register, or a
   // hardware bit operation on it, relatches the reference
   assign sp_access = access_ph & (hit_sp_pins | (hit_bit_op & pwrite & bop_to_sp));

   assign mon_pins = sp_pins[DPG_MON_HI:DPG_MON_LO];
   assign mon_inputs = sp_dir_q[DPG_MON_HI:DPG_MON_LO]; // RL13

   // A change landing in the relatch cycle is still compared with the
   // old reference, so it sets the flag before being absorbed
   always_ff @(posedge mclk) begin
      if (srst) begin
         ref_q <= DPG_REF_RST;
      end else if (sp_access) begin
         ref_q <= mon_pins; // RL15 RL18
      end
   end

   assign chg_mismatch = |((mon_pins ^ ref_q) & mon_inputs); // RL13 RL14

   // Set wins over a software clear in the same cycle
   always_comb begin
      chg_flag_d = chg_flag_q;
      if (chg_mismatch) begin
         chg_flag_d = 1'b1; // RL14 RL15 RL20
      end else if (wr_acc && hit_icr) begin
         chg_flag_d = pwdata[DPG_ICR_CHG_FLAG_BIT]; // RL16
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         chg_flag_q <= 1'b0;
      end else begin
         chg_flag_q <= chg_flag_d;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         gie_q <= 1'b0;
         chg_en_q <= 1'b0;
      end else if (wr_acc && hit_icr) begin
         gie_q <= pwdata[DPG_ICR_GIE_BIT];
         chg_en_q <= pwdata[DPG_ICR_CHG_EN_BIT];
      end
   end

   // ****************************************
   // Interrupt and wake
   // ****************************************
   // Global enable is left to the CPU so sleep wake still works with it off
   assign change_irq = chg_flag_q & chg_en_q; // RL21
   assign wake_req = sleep_mode & chg_flag_q & chg_en_q; // RL17 RL21

endmodule

// ### rtl/dpg_pin_sync.sv
// Two-stage synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module dpg_pin_sync #(
   parameter int W = 8
) (
   input wire logic mclk, // System clock
   input wire logic srst, // Synchronous reset, active high
   input wire logic [W-1:0] pin_async, // Raw pin levels
   output logic [W-1:0] pin_sync // Pin levels after two flops
);

   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   // First stage feeds only the second stage
   always_ff @(posedge mclk) begin
      if (srst) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= pin_async;
         sync_q <= meta_q;
      end
   end

   assign pin_sync = sync_q;

endmodule

// ### verif/dpg_gpio_chk.sv
// Port-level checker for the dual-port GPIO block
`timescale 1ns/1ps
module dpg_gpio_chk
   import dpg_pkg::*;
(
   input wire logic mclk, // Clock
   input wire logic srst, // Reset
   input wire logic psel, // Select
   input wire logic penable, // Enable
   input wire logic pwrite, // Write
   input wire logic [dpg_pkg::DPG_ADDR_W-1:0] paddr, // Address
   input wire logic [dpg_pkg::DPG_DATA_W-1:0] pwdata, // Write data
   input wire logic [dpg_pkg::DPG_DATA_W-1:0] prdata, // Read data
   input wire logic [dpg_pkg::DPG_FP_W-1:0] fp_pin_in, // First pins
   input wire logic [dpg_pkg::DPG_FP_W-1:0] fp_pin_out, // First drive
   input wire logic [dpg_pkg::DPG_FP_W-1:0] fp_pin_oe, // First enables
   input wire logic [dpg_pkg::DPG_SP_W-1:0] sp_pin_in, // Second pins
   input wire logic [dpg_pkg::DPG_SP_W-1:0] sp_pin_oe, // Second enables
   input wire logic [dpg_pkg::DPG_SP_W-1:0] sp_pullup_on, // Pull-ups
   input wire logic timer_ext_clk, // Timer clock
   input wire logic sleep_mode, // Asleep
   input wire logic change_irq, // Request
   input wire logic wake_req // Wake
);
   default clocking @(posedge mclk); endclocking
   default disable iff (srst);
   logic acc;
   assign acc = psel && penable;
   // ****************************************
   // Checks
   // ****************************************
   od_low_a: assert property (fp_pin_out[4] == 1'b0)
      else $error("open-drain pin driven high");
   rst_dir_a: assert property ($fell(srst) |-> fp_pin_oe == 5'h00 && sp_pin_oe == 8'h00)
      else $error("pins driven after reset");
   rst_pullup_a: assert property ($fell(srst) |-> sp_pullup_on == 8'h00)
      else $error("pull-ups on after reset");
   pullup_out_a: assert property ((sp_pullup_on & sp_pin_oe) == 8'h00)
      else $error("pull-up on an output pin");
   pullup_opt_a: assert property (acc && pwrite && paddr == 12'h204 && !pwdata[7]
      |=> sp_pullup_on == ~sp_pin_oe)
      else $error("pull-ups not following option");
   fp_dir_a: assert property (acc && pwrite && paddr == 12'h214
      |=> fp_pin_oe[3:0] == ~$past(pwdata[3:0]))
      else $error("first-port enables wrong");
   sp_dir_a: assert property (acc && pwrite && paddr == 12'h218
      |=> sp_pin_oe == ~$past(pwdata[7:0]))
      else $error("second-port enables wrong");
   fp_upper_a: assert property (acc && !pwrite && (paddr == 12'h014 || paddr == 12'h214)
      |-> prdata[31:5] == 27'h0)
      else $error("unimplemented bits not zero");
   sp_read_a: assert property (acc && !pwrite && paddr == 12'h018 && !$past(srst)
      && !$past(srst, 2) && !$past(srst, 3) |-> prdata[7:0] == $past(sp_pin_in, 3))
      else $error("port read is not pin level");
   tmr_clk_a: assert property (!$past(srst) && !$past(srst, 2)
      |-> timer_ext_clk == $past(fp_pin_in[4], 2))
      else $error("timer clock not from pin");
   wake_a: assert property (wake_req == (sleep_mode && change_irq))
      else $error("wake request wrong");
endmodule

bind dpg_gpio dpg_gpio_chk u_dpg_gpio_chk (.mclk(mclk), .srst(srst), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .fp_pin_in(fp_pin_in), .fp_pin_out(fp_pin_out), .fp_pin_oe(fp_pin_oe),
   .sp_pin_in(sp_pin_in), .sp_pin_oe(sp_pin_oe), .sp_pullup_on(sp_pullup_on),
   .timer_ext_clk(timer_ext_clk), .sleep_mode(sleep_mode), .change_irq(change_irq),
   .wake_req(wake_req));

// ### verif/dpg_gpio_tb.sv
// Self-checking bench for the dual-port GPIO block
`timescale 1ns/1ps
module dpg_gpio_tb;
   import dpg_pkg::*;
   localparam logic [11:0] a_fp = 12'h014, a_fd = 12'h214, a_sp = 12'h018, a_sd = 12'h218;
   localparam logic [11:0] a_opt = 12'h204, a_icr = 12'h02c, a_bop = 12'h240;
   logic mclk = 1'b0;
   logic srst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [DPG_ADDR_W-1:0] paddr = '0;
   logic [DPG_DATA_W-1:0] pwdata = '0;
   logic sleep_mode = 1'b0;
   logic [DPG_DATA_W-1:0] prdata, rd;
   logic pready, pslverr, timer_ext_clk, change_irq, wake_req, err;
   logic [DPG_FP_W-1:0] fp_pin_in, fp_pin_out, fp_pin_oe;
   logic [DPG_SP_W-1:0] sp_pin_in, sp_pin_out, sp_pin_oe, sp_pullup_on;
   logic [12:0] ext_val = '0;
   // Keypad holds second-port pins low so reset leaves no change pending
   logic [12:0] ext_en = 13'h1fe0;
   wire [12:0] pads;
   int fail_count = 0;
   int n_compared = 0;
   always #10 mclk = ~mclk;
   assign fp_pin_in = pads[4:0];
   assign sp_pin_in = pads[12:5];
   dpg_gpio u_dpg_gpio (.mclk(mclk), .srst(srst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .fp_pin_in(fp_pin_in), .fp_pin_out(fp_pin_out),
      .fp_pin_oe(fp_pin_oe), .sp_pin_in(sp_pin_in), .sp_pin_out(sp_pin_out),
      .sp_pin_oe(sp_pin_oe), .sp_pullup_on(sp_pullup_on), .timer_ext_clk(timer_ext_clk),
      .sleep_mode(sleep_mode), .change_irq(change_irq), .wake_req(wake_req));
   dpg_pad_model u_dpg_pad_model (.mclk(mclk), .pin_out({sp_pin_out, fp_pin_out}),
      .pin_oe({sp_pin_oe, fp_pin_oe}), .pull_on({sp_pullup_on, 5'h00}),
      .ext_val(ext_val), .ext_en(ext_en), .pin_lvl(pads));
   // ****************************************
   // Tasks
   // ****************************************
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // Idle cycle after each transfer keeps one assignment per step
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (n >= 16) begin
         fail_count++;
         conclude();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
      // Pin levels need two edges through the synchroniser
      repeat (2) @(posedge mclk);
      apb(1'b0, a, 32'h0);
      chk($sformatf("read %h", a), exp, rd);
   endtask
   // ****************************************
   // Sequence
   // ****************************************
   initial begin
      repeat (6) @(posedge mclk);
      srst <= 1'b0;
      @(posedge mclk);
      chk("fp_pin_oe", 32'h0, fp_pin_oe);
      chk("sp_pullup_on", 32'h0, sp_pullup_on);
      rdchk(a_fd, 32'h1f);
      rdchk(a_sd, 32'hff);
      rdchk(a_opt, 32'hff);
      rdchk(a_icr, 32'h0);
      rdchk(12'h300, 32'h0);
      chk("pslverr", 32'h1, err);
      ext_en <= 13'h1ff0;
      ext_val <= 13'h0010;
      apb(1'b1, a_fd, 32'h00);
      apb(1'b1, a_fp, 32'h1a);
      chk("fp_pin_oe", 32'h0f, fp_pin_oe);
      chk("fp_pin_out", 32'h0a, fp_pin_out);
      rdchk(a_fp, 32'h1a);
      chk("timer_ext_clk", 32'h1, timer_ext_clk);
      apb(1'b1, a_bop, 32'h42);
      chk("fp_pin_out", 32'h0e, fp_pin_out);
      ext_val <= 13'h0;
      apb(1'b1, a_fp, 32'h00);
      chk("fp_pin_oe", 32'h1f, fp_pin_oe);
      chk("timer_ext_clk", 32'h0, timer_ext_clk);
      apb(1'b1, a_fd, 32'hff);
      rdchk(a_fd, 32'h1f);
      ext_val <= {8'h5a, 5'h0};
      apb(1'b1, a_sp, 32'hff);
      chk("sp_pin_out", 32'hff, sp_pin_out);
      rdchk(a_sp, 32'h5a);
      apb(1'b1, a_sd, 32'h00);
      chk("sp_pin_oe", 32'hff, sp_pin_oe);
      rdchk(a_sp, 32'hff);
      ext_val <= {8'ha0, 5'h0};
      apb(1'b1, a_sd, 32'hf0);
      apb(1'b1, a_sp, 32'h05);
      apb(1'b1, a_bop, 32'hc1);
      chk("sp_pin_out", 32'ha7, sp_pin_out);
      apb(1'b1, a_opt, 32'h7f);
      chk("sp_pullup_on", 32'hf0, sp_pullup_on);
      apb(1'b1, a_opt, 32'hff);
      chk("sp_pullup_on", 32'h0, sp_pullup_on);
      apb(1'b0, a_sp, 32'h0);
      apb(1'b1, a_icr, 32'h00);
      repeat (4) @(posedge mclk);
      rdchk(a_icr, 32'h0);
      ext_val <= {8'h80, 5'h0};
      repeat (4) @(posedge mclk);
      rdchk(a_icr, 32'h01);
      chk("change_irq", 32'h0, change_irq);
      apb(1'b1, a_icr, 32'h08);
      rdchk(a_icr, 32'h09);
      chk("change_irq", 32'h1, change_irq);
      sleep_mode <= 1'b1;
      @(posedge mclk);
      chk("wake_req", 32'h1, wake_req);
      sleep_mode <= 1'b0;
      apb(1'b0, a_sp, 32'h0);
      apb(1'b1, a_icr, 32'h08);
      rdchk(a_icr, 32'h08);
      chk("change_irq", 32'h0, change_irq);
      apb(1'b1, a_sd, 32'h0f);
      repeat (5) @(posedge mclk);
      rdchk(a_icr, 32'h08);
      conclude();
   end
endmodule

// ### verif/dpg_pad_model.sv
// Pin-level model of the external devices on both ports
`timescale 1ns/1ps
module dpg_pad_model (
   input wire logic mclk, // Clock for the float pattern
   input wire logic [12:0] pin_out, // Block drive values
   input wire logic [12:0] pin_oe, // Block drive enables
   input wire logic [12:0] pull_on, // Weak pull-ups
   input wire logic [12:0] ext_val, // Keypad values
   input wire logic [12:0] ext_en, // Keypad drive enables
   output logic [12:0] pin_lvl // Resolved levels
);
   // Floating pins toggle each cycle so no stale level is read
   logic [12:0] float_q = 13'h0aaa;
   always @(posedge mclk) begin
      float_q <= ~float_q;
   end
   assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
      | (~pin_oe & ~ext_en & (pull_on | float_q));
endmodule
